// file: rtl/sse_exec.sv
// Execution unit for the three subtract instructions and the power-down instruction.
`timescale 1ns/1ps

// Behaviour
// - Subtract register and inverted carry from working
// - Destination bit zero writes working, one file
// - Bank bit zero selects access bank
// - Literal minus working, result into working
// - Carry means no borrow; negative sets flag
// - Watchdog wake clears the time-out flag
// - Power-down clears power-down flag, sets time-out flag, clears watchdog, stops oscillator
module sse_exec
	import sse_pkg::*;
#(
	parameter int BANKS = 16
)
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR,
	input wire logic WORKING_WE,
	input wire logic [7:0] WORKING_WDATA,
	input wire logic BANK_SELECT_WE,
	input wire logic [BANK_W-1:0] BANK_SELECT_WDATA,
	input wire logic CARRY_WE,
	input wire logic CARRY_WDATA,
	input wire logic MEM_WE,
	input wire logic [ADDR_W-1:0] MEM_ADDR,
	input wire logic [7:0] MEM_WDATA,
	input wire logic WAKE_WATCHDOG,
	input wire logic WAKE_OTHER,
	output logic [7:0] WORKING_REGISTER,
	output logic [BANK_W-1:0] BANK_SELECT_REGISTER,
	output sse_flags_s FLAGS,
	output logic [7:0] MEM_RDATA,
	output logic TIME_OUT_FLAG_N,
	output logic POWER_DOWN_FLAG_N,
	output logic WATCHDOG_CLEAR,
	output logic OSC_STOP
);

	logic [7:0] file_mem [0:BANKS*256-1];
	logic [7:0] working_reg;
	logic [BANK_W-1:0] bank_select_reg;
	sse_flags_s flags_reg;
	logic [7:0] mem_rdata_reg;
	logic time_out_reg;
	logic power_down_reg;
	logic watchdog_clear_reg;
	logic asleep_reg;
	logic [2:0] wake_wdog_sync_reg;
	logic [2:0] wake_oth_sync_reg;
	logic wake_wdog_reg;
	logic wake_oth_reg;

	wire [5:0] opc_fmt;
	wire [7:0] opc_lit;
	wire [7:0] file_offset;
	wire dest_bit;
	wire bank_bit;
	wire [BANK_W-1:0] access_bank;
	wire [BANK_W-1:0] eff_bank;
	wire [ADDR_W-1:0] file_addr;
	wire [7:0] file_data;
	wire exec_en;
	sse_op_e op;
	wire is_sub;
	wire [7:0] alu_a;
	wire [7:0] alu_b;
	wire alu_cin;
	wire [7:0] alu_result;
	sse_flags_s alu_flags;
	wire write_file;
	wire write_working;
	wire enter_sleep;
	wire wake_any;

	// Field extraction from the instruction word.
	assign opc_fmt = INSTR[OPC_HI:OPC_FMT_LO];
	assign opc_lit = INSTR[OPC_HI:OPC_LIT_LO];
	assign file_offset = INSTR[7:0];
	assign dest_bit = INSTR[DEST_BIT];
	assign bank_bit = INSTR[BANK_BIT];

	// Instructions are held off while the core sleeps.
	assign exec_en = INSTR_VALID & ~asleep_reg;

	// Decode: anything outside this subset is ignored.
	assign op = !exec_en ? SSE_OP_NONE :
		(opc_fmt == OPC_SUB_REG_FROM_WORKING_REGISTER_BORROW) ? SSE_OP_SUB_BORROW :
		(opc_fmt == OPC_SUB_WORKING_REGISTER_FROM_REG) ? SSE_OP_SUB_REG :
		(opc_lit == OPC_SUB_WORKING_REGISTER_FROM_LITERAL) ? SSE_OP_SUB_LIT :
		(INSTR == OPC_POWER_DOWN) ? SSE_OP_SLEEP : SSE_OP_NONE;
	assign is_sub = (op == SSE_OP_SUB_BORROW) | (op == SSE_OP_SUB_REG) | (op == SSE_OP_SUB_LIT);

	// Bank resolution; the access bank splits its range between bank zero and the top bank.
	assign access_bank = (file_offset < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
	assign eff_bank = (bank_bit == BANK_USE_ACCESS) ? access_bank : bank_select_reg;
	assign file_addr = {eff_bank, file_offset};
	assign file_data = file_mem[file_addr];

	// Operand selection per subtract flavour.
	// The literal shares the low byte with the file offset, so no extra field is needed.
	assign alu_a = (op == SSE_OP_SUB_BORROW) ? working_reg :
		(op == SSE_OP_SUB_REG) ? file_data : file_offset;
	assign alu_b = (op == SSE_OP_SUB_BORROW) ? file_data : working_reg;
	// Only the borrow form consumes carry; the others subtract with no borrow in.
	assign alu_cin = (op == SSE_OP_SUB_BORROW) ? flags_reg.carry : 1'h1;

	sse_subtractor u_sub (
		.minuend(alu_a),
		.subtrahend(alu_b),
		.carry_in(alu_cin),
		.result(alu_result),
		.flags(alu_flags)
	);

	// Destination steering; the literal form always lands in the working register.
	assign write_working = (op == SSE_OP_SUB_LIT) |
		(is_sub & (op != SSE_OP_SUB_LIT) & (dest_bit == DEST_TO_WORKING));
	assign write_file = is_sub & (op != SSE_OP_SUB_LIT) & (dest_bit != DEST_TO_WORKING);
	assign enter_sleep = (op == SSE_OP_SLEEP);
	assign wake_any = asleep_reg & (wake_wdog_reg | wake_oth_reg);

	// File register array; an instruction write takes the port over a load from outside.
	always_ff @(posedge CLK)
	begin
		if (write_file)
			file_mem[file_addr] <= alu_result;
		else if (MEM_WE)
			file_mem[MEM_ADDR] <= MEM_WDATA;
	end

	// Registered read-back of the array for observation.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			mem_rdata_reg <= 8'h00;
		else
			mem_rdata_reg <= file_mem[MEM_ADDR];
	end

	// Working register; execution wins over an outside load in the same cycle.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			working_reg <= WORKING_RESET;
		else if (write_working)
			working_reg <= alu_result;
		else if (WORKING_WE)
			working_reg <= WORKING_WDATA;
	end

	// Bank select register, loaded only from outside.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			bank_select_reg <= BANK_SELECT_RESET;
		else if (BANK_SELECT_WE)
			bank_select_reg <= BANK_SELECT_WDATA;
	end

	// Arithmetic flags; an outside carry load is overridden by a subtract.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			flags_reg <= FLAGS_RESET;
		else if (is_sub)
			flags_reg <= alu_flags;
		else if (CARRY_WE)
			flags_reg.carry <= CARRY_WDATA;
	end

	// Wake inputs come from other clock domains, so each passes three stages.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wake_wdog_sync_reg <= 3'h0;
			wake_oth_sync_reg <= 3'h0;
		end
		else
		begin
			wake_wdog_sync_reg <= {wake_wdog_sync_reg[1:0], WAKE_WATCHDOG};
			wake_oth_sync_reg <= {wake_oth_sync_reg[1:0], WAKE_OTHER};
		end
	end

	// A level is accepted only when the second and third stages agree.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wake_wdog_reg <= 1'h0;
			wake_oth_reg <= 1'h0;
		end
		else
		begin
			if (wake_wdog_sync_reg[1] == wake_wdog_sync_reg[2])
				wake_wdog_reg <= wake_wdog_sync_reg[2];
			if (wake_oth_sync_reg[1] == wake_oth_sync_reg[2])
				wake_oth_reg <= wake_oth_sync_reg[2];
		end
	end

	// Power-down sequencing and status; sleep and wake can never coincide.
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			time_out_reg <= TIME_OUT_RESET;
			power_down_reg <= POWER_DOWN_RESET;
			watchdog_clear_reg <= 1'h0;
			asleep_reg <= 1'h0;
		end
		else
		begin
			watchdog_clear_reg <= enter_sleep;
			if (enter_sleep)
			begin
				power_down_reg <= 1'h0;
				time_out_reg <= 1'h1;
				asleep_reg <= 1'h1;
			end
			else if (wake_any)
			begin
				asleep_reg <= 1'h0;
				// A watchdog wake is recorded even when another source fires too.
				if (wake_wdog_reg)
					time_out_reg <= 1'h0;
			end
		end
	end

	assign WORKING_REGISTER = working_reg;
	assign BANK_SELECT_REGISTER = bank_select_reg;
	assign FLAGS = flags_reg;
	assign MEM_RDATA = mem_rdata_reg;
	assign TIME_OUT_FLAG_N = time_out_reg;
	assign POWER_DOWN_FLAG_N = power_down_reg;
	assign WATCHDOG_CLEAR = watchdog_clear_reg;
	assign OSC_STOP = asleep_reg;

endmodule : sse_exec

// file: rtl/sse_pkg.sv
// Shared constants and types for the subtract and power-down execution block.
package sse_pkg;

	// Opcode field positions and prefixes.
	localparam int OPC_HI = 15;
	localparam int OPC_FMT_LO = 10;
	localparam int OPC_LIT_LO = 8;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam logic [5:0] OPC_SUB_REG_FROM_WORKING_REGISTER_BORROW = 6'h15;
	localparam logic [5:0] OPC_SUB_WORKING_REGISTER_FROM_REG = 6'h17;
	localparam logic [7:0] OPC_SUB_WORKING_REGISTER_FROM_LITERAL = 8'h08;
	localparam logic [15:0] OPC_POWER_DOWN = 16'h0003;

	// Operand bit meanings.
	localparam logic DEST_TO_WORKING = 1'h0;
	localparam logic BANK_USE_ACCESS = 1'h0;

	// File register addressing.
	localparam int BANK_W = 4;
	localparam int ADDR_W = 12;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

	// Values after reset.
	localparam logic [7:0] WORKING_RESET = 8'h00;
	localparam logic [BANK_W-1:0] BANK_SELECT_RESET = 4'h0;
	localparam logic TIME_OUT_RESET = 1'h1;
	localparam logic POWER_DOWN_RESET = 1'h1;

	// Arithmetic flags produced by the subtractor.
	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic overflow;
		logic zero;
		logic negative;
	} sse_flags_s;

	localparam sse_flags_s FLAGS_RESET = '0;

	// Decoded instruction class.
	typedef enum logic [2:0] {
		SSE_OP_NONE,
		SSE_OP_SUB_BORROW,
		SSE_OP_SUB_REG,
		SSE_OP_SUB_LIT,
		SSE_OP_SLEEP
	} sse_op_e;

endpackage : sse_pkg

// file: rtl/sse_subtractor.sv
// Eight-bit two's complement subtractor with borrow and flag generation.
`timescale 1ns/1ps
module sse_subtractor
	import sse_pkg::*;
(
	input wire logic [7:0] minuend,
	input wire logic [7:0] subtrahend,
	input wire logic carry_in,
	output logic [7:0] result,
	output sse_flags_s flags
);

	wire [8:0] full_sum;
	wire [4:0] low_sum;
	wire [7:0] inverted;

	// Subtraction as addition of the complement; carry in set means no borrow.
	assign inverted = ~subtrahend;
	assign full_sum = {1'h0, minuend} + {1'h0, inverted} + {8'h00, carry_in};
	assign low_sum = {1'h0, minuend[3:0]} + {1'h0, inverted[3:0]} + {4'h0, carry_in};
	assign result = full_sum[7:0];

	// Carry clears exactly when the true result drops below zero.
	assign flags.carry = full_sum[8];
	assign flags.digit_carry = low_sum[4];
	assign flags.overflow = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_sum[7]);
	assign flags.zero = (full_sum[7:0] == 8'h00);
	assign flags.negative = full_sum[7];

endmodule : sse_subtractor

// file: tb/sse_exec_assertions.sv
// Concurrent checks on the ports of the subtract and power-down execution block.
`timescale 1ns/1ps
module sse_exec_assertions
	import sse_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic INSTR_VALID,
	input wire logic [15:0] INSTR,
	input wire logic WAKE_WATCHDOG,
	input wire logic [7:0] WORKING_REGISTER,
	input wire sse_flags_s FLAGS,
	input wire logic TIME_OUT_FLAG_N,
	input wire logic POWER_DOWN_FLAG_N,
	input wire logic WATCHDOG_CLEAR,
	input wire logic OSC_STOP
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Instructions count only while the oscillator runs.
	wire logic go = INSTR_VALID && !OSC_STOP;
	wire logic sleep_op = go && (INSTR == OPC_POWER_DOWN);
	wire logic lit_op = go && (INSTR[OPC_HI:OPC_LIT_LO] == OPC_SUB_WORKING_REGISTER_FROM_LITERAL);
	// Power-down status, watchdog clear pulse and the sticky power-down bit.
	a_sleep_status: assert property (sleep_op |=> !POWER_DOWN_FLAG_N && TIME_OUT_FLAG_N && OSC_STOP)
		else $error("power-down status wrong");
	a_wdog_pulse: assert property (sleep_op |=> WATCHDOG_CLEAR ##1 !WATCHDOG_CLEAR)
		else $error("watchdog clear not a single pulse");
	a_pdown_sticky: assert property (!POWER_DOWN_FLAG_N |=> !POWER_DOWN_FLAG_N)
		else $error("power-down bit released without reset");
	// Literal subtract result and carry, worked from the values before the edge; negative and zero checked against the new result.
	a_lit_result: assert property (lit_op |=> WORKING_REGISTER == 8'($past(INSTR[7:0]) - $past(WORKING_REGISTER)))
		else $error("literal subtract result wrong");
	a_lit_carry: assert property (lit_op |=> FLAGS.carry == ($past(INSTR[7:0]) >= $past(WORKING_REGISTER)))
		else $error("carry is not the inverted borrow");
	a_lit_sign: assert property (lit_op |=> FLAGS.negative == WORKING_REGISTER[7] && FLAGS.zero == (WORKING_REGISTER == 8'h00))
		else $error("negative or zero flag wrong");
	// The filtered wake path is a few flops long, so a bounded window is allowed.
	a_wdog_wake: assert property ($rose(WAKE_WATCHDOG) && OSC_STOP |-> ##[1:8] (!OSC_STOP && !TIME_OUT_FLAG_N))
		else $error("watchdog wake did not clear the time-out bit");
	a_tout_cause: assert property ($fell(TIME_OUT_FLAG_N) |-> $past(OSC_STOP))
		else $error("time-out bit cleared while awake");
	c_sleep: cover property (sleep_op);
	c_lit: cover property (lit_op);
	c_wake: cover property ($fell(OSC_STOP));
endmodule : sse_exec_assertions

bind sse_exec sse_exec_assertions u_chk (.CLK, .RSTN, .INSTR_VALID, .INSTR, .WAKE_WATCHDOG,
	.WORKING_REGISTER, .FLAGS, .TIME_OUT_FLAG_N, .POWER_DOWN_FLAG_N, .WATCHDOG_CLEAR, .OSC_STOP);

// file: tb/sse_exec_tb.sv
// Self-checking bench for the subtract and power-down execution block.
`timescale 1ns/1ps
module sse_exec_tb
	import sse_pkg::*;
();
	typedef struct packed {
		logic [15:0] op;
		logic [11:0] addr;
		logic [7:0] w;
		logic [7:0] f;
		logic c;
		logic to_w;
		logic [7:0] res;
		logic [2:0] czn;
	} sse_row_s;
	// Rows with a=0 and an offset below the split would read an unwritten bank if misrouted.
	sse_row_s rows [0:9] = '{
		'{16'h5603, 12'h003, 8'h02, 8'h03, 1'b1, 1'b0, 8'hFF, 3'h1},
		'{16'h5490, 12'hF90, 8'h05, 8'h02, 1'b1, 1'b1, 8'h03, 3'h4},
		'{16'h5610, 12'h010, 8'h02, 8'h01, 1'b0, 1'b0, 8'h00, 3'h6},
		'{16'h5F20, 12'h520, 8'h02, 8'h03, 1'b0, 1'b0, 8'h01, 3'h4},
		'{16'h5C85, 12'hF85, 8'h02, 8'h02, 1'b0, 1'b1, 8'h00, 3'h6},
		'{16'h5FA0, 12'h5A0, 8'h02, 8'h01, 1'b1, 1'b0, 8'hFF, 3'h1},
		'{16'h0802, 12'h000, 8'h01, 8'h00, 1'b0, 1'b1, 8'h01, 3'h4},
		'{16'h0802, 12'h000, 8'h02, 8'h00, 1'b0, 1'b1, 8'h00, 3'h6},
		'{16'h0802, 12'h000, 8'h03, 8'h00, 1'b1, 1'b1, 8'hFF, 3'h1},
		'{16'h577F, 12'h57F, 8'h00, 8'hFF, 1'b0, 1'b0, 8'h00, 3'h2}};
	logic CLK = 0, RSTN = 0, iv = 0, wwe = 0, bwe = 0, cwe = 0, cd = 0, mwe = 0, ww = 0, wo = 0;
	logic [15:0] instr = 16'h0000;
	logic [7:0] wd = 8'h00, md = 8'h00, w, rd;
	logic [3:0] bd = 4'h0, bank_select_register;
	logic [11:0] ma = 12'h000;
	logic tout_n, pdown_n, wclr, ostop;
	sse_flags_s fl;
	int failures = 0, checks_done = 0, cycles = 0;
	wire logic [7:0] st = {4'h0, tout_n, pdown_n, wclr, ostop};

	sse_exec u_dut (.CLK(CLK), .RSTN(RSTN), .INSTR_VALID(iv), .INSTR(instr), .WORKING_WE(wwe),
		.WORKING_WDATA(wd), .BANK_SELECT_WE(bwe), .BANK_SELECT_WDATA(bd), .CARRY_WE(cwe),
		.CARRY_WDATA(cd), .MEM_WE(mwe), .MEM_ADDR(ma), .MEM_WDATA(md), .WAKE_WATCHDOG(ww),
		.WAKE_OTHER(wo), .WORKING_REGISTER(w), .BANK_SELECT_REGISTER(bank_select_register), .FLAGS(fl),
		.MEM_RDATA(rd), .TIME_OUT_FLAG_N(tout_n), .POWER_DOWN_FLAG_N(pdown_n),
		.WATCHDOG_CLEAR(wclr), .OSC_STOP(ostop));

	// Clock and a hang guard well above the seventy or so cycles the run needs.
	always #4 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 1000)
			give_verdict(1'b1);
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(negedge CLK);
	endtask : tick

	task give_verdict(input logic hang);
		failures += int'(hang);
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// All inputs move on the falling edge so the rising edge sees settled values.
	initial
	begin
		tick(12);
		chk(st, 8'h0C);
		chk(w, WORKING_RESET);
		chk({3'h0, fl}, {3'h0, FLAGS_RESET});
		RSTN = 1;
		{bwe, bd} = 5'h15;
		tick(1);
		bwe = 0;
		chk({4'h0, bank_select_register}, 8'h05);
		foreach (rows[i])
		begin
			{wwe, cwe, mwe} = 3'h7;
			{wd, cd, ma, md} = {rows[i].w, rows[i].c, rows[i].addr, rows[i].f};
			tick(1);
			{wwe, cwe, mwe, iv} = 4'h1;
			instr = rows[i].op;
			tick(1);
			iv = 0;
			chk({5'h00, fl.carry, fl.zero, fl.negative}, {5'h00, rows[i].czn});
			chk(w, rows[i].to_w ? rows[i].res : rows[i].w);
			tick(1);
			if (!rows[i].to_w)
				chk(rd, rows[i].res);
		end
		// Power-down, then an instruction that must be ignored while asleep.
		{iv, instr} = {1'b1, OPC_POWER_DOWN};
		tick(1);
		instr = 16'h0802;
		chk(st, 8'h0B);
		tick(1);
		iv = 0;
		chk(st, 8'h09);
		chk(w, 8'h00);
		ww = 1;
		tick(8);
		ww = 0;
		chk(st, 8'h00);
		// The filtered wake level lags the pin, so let it drain before sleeping again.
		tick(5);
		// A wake from another source leaves the time-out bit set.
		{iv, instr} = {1'b1, OPC_POWER_DOWN};
		tick(1);
		{iv, wo} = 2'h1;
		tick(8);
		wo = 0;
		chk(st, 8'h08);
		// Back-to-back literal subtracts, each seeing the previous result.
		{iv, instr} = {1'b1, 16'h0805};
		tick(1);
		instr = 16'h0807;
		tick(1);
		iv = 0;
		chk(w, 8'h02);
		// Reset in mid-run, then literal subtracts from the first edge after release.
		RSTN = 0;
		tick(2);
		chk(st, 8'h0C);
		chk(w, WORKING_RESET);
		{RSTN, iv, instr} = {2'h3, 16'h0805};
		tick(1);
		instr = 16'h0880;
		chk(w, 8'h05);
		chk({3'h0, fl}, 8'h18);
		tick(1);
		iv = 0;
		chk(w, 8'h7B);
		chk({3'h0, fl}, 8'h14);
		give_verdict(1'b0);
	end
endmodule : sse_exec_tb
